// ---- adpp_consts.svh ----
/*
 Bit positions and reset values for the converter's parallel data port.
 Assumes it is included by its bare name from the package and from adpp_port.
*/
`ifndef ADPP_CONSTS_SVH
`define ADPP_CONSTS_SVH
`define ADPP_WORD_W     12
`define ADPP_CHAN_W     3
`define ADPP_LOW_W      8
`define ADPP_HIGH_W     3
`define ADPP_SYNC_W     16
`define ADPP_SYNC_RST   16'he000
`define ADPP_NIB_LSB    8
`define ADPP_CHAN_LSB   4
`define ADPP_TEN_PAD    2
`define ADPP_WORD_RST   12'h000
`define ADPP_BYTE_RST   8'h00
`endif

// ---- adpp_pkg.sv ----
/*
 Types for the converter's parallel data port.
 Assumes adpp_consts.svh is on the include path.
*/
`include "adpp_consts.svh"
package adpp_pkg;
   typedef enum logic [1:0] {ADPP_IDLE, ADPP_READ, ADPP_WRITE} adpp_state_t;
   typedef logic [`ADPP_WORD_W-1:0] adpp_word_t;
endpackage

// ---- adpp_sync.sv ----
/*
 Three-stage pin synchroniser with a two-sample agreement filter.
 Assumes asynchronous pins and one system clock.
*/
`timescale 1ns/1ps
module adpp_sync #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pins in, filtered levels out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q, s2_q, s3_q, out_q;
         logic s1_d, s2_d, s3_d, out_d;
         always_comb begin
            s1_d  = din[i];
            s2_d  = s1_q;
            s3_d  = s2_q;
            // Only a level seen twice in a row counts
            out_d = (s2_q == s3_q) ? s3_q : out_q;
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_q  <= RST_VAL[i];
               s2_q  <= RST_VAL[i];
               s3_q  <= RST_VAL[i];
               out_q <= RST_VAL[i];
            end else begin
               s1_q  <= s1_d;
               s2_q  <= s2_d;
               s3_q  <= s3_d;
               out_q <= out_d;
            end
         end
         assign dout[i] = out_q;
      end
   endgenerate
endmodule

// ---- adpp_port.sv ----
/*
 Parallel host data port of an eight-channel converter: result reads
 and register writes in word or byte mode.
 Assumes RESULT and RESULT_CHAN come from logic on SYS_CLK; all bus
 pins are asynchronous and pass the three-stage synchroniser.
*/
`timescale 1ns/1ps
`include "adpp_consts.svh"
module adpp_port
   import adpp_pkg::*;
#(
   parameter bit TEN_BIT = 1'b0
) (
   // Clock and reset
   input  wire logic                    SYS_CLK,
   input  wire logic                    RST,
   // Bus strobes and mode pin
   input  wire logic                    CS_N,
   input  wire logic                    RD_N,
   input  wire logic                    WR_N,
   input  wire logic                    WORD_MODE,
   // Low data lines, bits 0 to 7
   input  wire logic [`ADPP_LOW_W-1:0]  LOW_DATA_LINES_I,
   output logic      [`ADPP_LOW_W-1:0]  LOW_DATA_LINES_O,
   output logic                         LOW_DATA_LINES_OE,
   // Shared pin: bit 8 or upper byte select
   input  wire logic                    BIT8_OR_UPPER_BYTE_SELECT_I,
   output logic                         BIT8_OR_UPPER_BYTE_SELECT_O,
   output logic                         BIT8_OR_UPPER_BYTE_SELECT_OE,
   // Data lines 9 to 11
   input  wire logic [`ADPP_HIGH_W-1:0] HIGH_DATA_LINES_I,
   output logic      [`ADPP_HIGH_W-1:0] HIGH_DATA_LINES_O,
   output logic                         HIGH_DATA_LINES_OE,
   // Conversion result side
   input  wire logic [`ADPP_WORD_W-1:0] RESULT,
   input  wire logic [`ADPP_CHAN_W-1:0] RESULT_CHAN,
   // Register write side
   output logic      [`ADPP_WORD_W-1:0] WR_WORD,
   output logic                         WR_STROBE
);
   logic [`ADPP_SYNC_W-1:0] pins_s;
   logic                    cs_n_s, rd_n_s, wr_n_s, word_s, bit8_s;
   logic [`ADPP_HIGH_W-1:0] high_s;
   logic [`ADPP_LOW_W-1:0]  low_s;
   logic                    rd_act, wr_act;
   adpp_word_t              rd_word;

   adpp_sync #(
      .W       (`ADPP_SYNC_W),
      .RST_VAL (`ADPP_SYNC_RST)
   ) u_sync (
      .clk  (SYS_CLK),
      .rst  (RST),
      .din  ({CS_N, RD_N, WR_N, WORD_MODE, BIT8_OR_UPPER_BYTE_SELECT_I,
              HIGH_DATA_LINES_I, LOW_DATA_LINES_I}),
      .dout (pins_s)
   );

   assign {cs_n_s, rd_n_s, wr_n_s, word_s, bit8_s, high_s, low_s} = pins_s;
   assign rd_act = ~cs_n_s & ~rd_n_s;
   assign wr_act = ~cs_n_s & ~wr_n_s;
   // Ten-bit part left-justifies, padding the two lowest bits
   assign rd_word = TEN_BIT ?
      {RESULT[`ADPP_WORD_W-`ADPP_TEN_PAD-1:0], {`ADPP_TEN_PAD{1'b0}}} :
      RESULT;

   adpp_state_t             state_q, state_d;
   logic [`ADPP_LOW_W-1:0]  low_o_q, low_o_d;
   logic                    low_oe_q, low_oe_d;
   logic                    b8_o_q, b8_o_d, b8_oe_q, b8_oe_d;
   logic [`ADPP_HIGH_W-1:0] high_o_q, high_o_d;
   logic                    high_oe_q, high_oe_d;
   logic [`ADPP_LOW_W-1:0]  low_hold_q, low_hold_d;
   adpp_word_t              wr_word_q, wr_word_d;
   logic                    wr_stb_q, wr_stb_d;

   always_comb begin
      state_d    = state_q;
      low_hold_d = low_hold_q;
      wr_word_d  = wr_word_q;
      wr_stb_d   = 1'b0;
      case (state_q)
         ADPP_IDLE: begin
            if (rd_act) begin
               state_d = ADPP_READ;
            end else if (wr_act) begin
               state_d = ADPP_WRITE;
            end
         end
         ADPP_READ: begin
            if (!rd_act) begin
               state_d = ADPP_IDLE;
            end
         end
         ADPP_WRITE: begin
            // Capture on the strobe's release, data still held
            if (!wr_act) begin
               state_d = ADPP_IDLE;
               if (word_s) begin
                  wr_word_d = {high_s, bit8_s, low_s};
                  wr_stb_d  = 1'b1;
               end else if (!bit8_s) begin
                  low_hold_d = low_s;
               end else begin
                  // Bits 4-7 ignored; host must send zeros
                  wr_word_d = {low_s[`ADPP_CHAN_LSB-1:0], low_hold_q};
                  wr_stb_d  = 1'b1;
               end
            end
         end
         default: begin
            state_d = ADPP_IDLE;
         end
      endcase
   end

   always_comb begin
      // Drivers follow the next state so release costs no extra cycle
      low_oe_d  = (state_d == ADPP_READ);
      b8_oe_d   = low_oe_d & word_s;
      high_oe_d = low_oe_d & word_s;
      b8_o_d    = 1'b0;
      high_o_d  = '0;
      low_o_d   = '0;
      if (low_oe_d) begin
         if (word_s) begin
            low_o_d  = rd_word[`ADPP_LOW_W-1:0];
            b8_o_d   = rd_word[`ADPP_NIB_LSB];
            high_o_d = rd_word[`ADPP_WORD_W-1:`ADPP_WORD_W-`ADPP_HIGH_W];
         end else if (bit8_s) begin
            // Channel id beside the top nibble
            low_o_d = {1'b0, RESULT_CHAN,
                       rd_word[`ADPP_WORD_W-1:`ADPP_NIB_LSB]};
         end else begin
            low_o_d = rd_word[`ADPP_LOW_W-1:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_q    <= ADPP_IDLE;
         low_o_q    <= `ADPP_BYTE_RST;
         low_oe_q   <= 1'b0;
         b8_o_q     <= 1'b0;
         b8_oe_q    <= 1'b0;
         high_o_q   <= '0;
         high_oe_q  <= 1'b0;
         low_hold_q <= `ADPP_BYTE_RST;
         wr_word_q  <= `ADPP_WORD_RST;
         wr_stb_q   <= 1'b0;
      end else begin
         state_q    <= state_d;
         low_o_q    <= low_o_d;
         low_oe_q   <= low_oe_d;
         b8_o_q     <= b8_o_d;
         b8_oe_q    <= b8_oe_d;
         high_o_q   <= high_o_d;
         high_oe_q  <= high_oe_d;
         low_hold_q <= low_hold_d;
         wr_word_q  <= wr_word_d;
         wr_stb_q   <= wr_stb_d;
      end
   end

   assign LOW_DATA_LINES_O             = low_o_q;
   assign LOW_DATA_LINES_OE            = low_oe_q;
   assign BIT8_OR_UPPER_BYTE_SELECT_O  = b8_o_q;
   assign BIT8_OR_UPPER_BYTE_SELECT_OE = b8_oe_q;
   assign HIGH_DATA_LINES_O            = high_o_q;
   assign HIGH_DATA_LINES_OE           = high_oe_q;
   assign WR_WORD                      = wr_word_q;
   assign WR_STROBE                    = wr_stb_q;

   property p_float_idle;
      @(posedge SYS_CLK) disable iff (RST)
      !rd_act |=> !LOW_DATA_LINES_OE && !HIGH_DATA_LINES_OE;
   endproperty
   a_float_idle: assert property (p_float_idle)
      else $error("data pins driven without select and read");

   property p_read_drive;
      @(posedge SYS_CLK) disable iff (RST)
      (state_q == ADPP_IDLE) && rd_act |=> LOW_DATA_LINES_OE;
   endproperty
   a_read_drive: assert property (p_read_drive)
      else $error("read not answered one cycle after strobe");

   property p_ten_word;
      @(posedge SYS_CLK) disable iff (RST)
      TEN_BIT && LOW_DATA_LINES_OE && $past(word_s)
         |-> LOW_DATA_LINES_O[1:0] == 2'h0;
   endproperty
   a_ten_word: assert property (p_ten_word)
      else $error("ten-bit word read with nonzero low bits");

   property p_bit8_dir;
      @(posedge SYS_CLK) disable iff (RST)
      BIT8_OR_UPPER_BYTE_SELECT_OE |-> $past(word_s) && $past(rd_act);
   endproperty
   a_bit8_dir: assert property (p_bit8_dir)
      else $error("shared pin driven in byte mode");

   property p_byte_low;
      @(posedge SYS_CLK) disable iff (RST)
      LOW_DATA_LINES_OE && !$past(word_s) && !$past(bit8_s)
         |-> LOW_DATA_LINES_O == $past(rd_word[7:0]);
   endproperty
   a_byte_low: assert property (p_byte_low)
      else $error("low byte read carries wrong data");

   property p_byte_high;
      @(posedge SYS_CLK) disable iff (RST)
      LOW_DATA_LINES_OE && !$past(word_s) && $past(bit8_s)
         |-> LOW_DATA_LINES_O[3:0] == $past(rd_word[11:8])
             && LOW_DATA_LINES_O[6:4] == $past(RESULT_CHAN)
             && !LOW_DATA_LINES_O[7];
   endproperty
   a_byte_high: assert property (p_byte_high)
      else $error("upper byte read carries wrong nibble or channel");

   property p_ten_byte;
      @(posedge SYS_CLK) disable iff (RST)
      TEN_BIT && LOW_DATA_LINES_OE && !$past(word_s) && !$past(bit8_s)
         |-> LOW_DATA_LINES_O[1:0] == 2'h0
             && LOW_DATA_LINES_O[7:2] == $past(RESULT[5:0]);
   endproperty
   a_ten_byte: assert property (p_ten_byte)
      else $error("ten-bit low byte malformed");

   property p_word_write;
      @(posedge SYS_CLK) disable iff (RST)
      (state_q == ADPP_WRITE) && !wr_act && word_s
         |=> WR_STROBE && WR_WORD == $past({high_s, bit8_s, low_s})
         ##1 !WR_STROBE;
   endproperty
   a_word_write: assert property (p_word_write)
      else $error("word write not captured as one pulse");
endmodule

// ---- adpp_host.sv ----
/*
 Host bus master model for the converter data port.
 Assumes the bench resolves each pin from the device's enables alone.
*/
`timescale 1ns/1ps
module adpp_host (
   // Clock and device enable
   input  wire logic        clk,
   input  wire logic        dev_oe,
   // Strobes, active low
   output logic             cs_n,
   output logic             rd_n,
   output logic             wr_n,
   // Pin drive: {bits 11-9, shared pin, bits 7-0}
   output logic [11:0]      v
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      v    = 12'h000;
   end
   // Reads return with the request still held
   task automatic go(input logic wr, input logic [11:0] d, output logic ok);
      ok = 1'b1;
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= wr;
      wr_n <= !wr;
      v    <= d;
      if (wr) begin
         // Data held well past the rise for the sync path
         repeat (6) @(posedge clk);
         cs_n <= 1'b1;
         wr_n <= 1'b1;
         repeat (6) @(posedge clk);
         v <= ~d;
      end else begin
         ok = 1'b0;
         for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk);
            #1 ok = dev_oe;
         end
      end
   endtask
   task automatic rel(output logic ok);
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      v    <= ~v;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge clk);
         #1 ok = !dev_oe;
      end
      repeat (4) @(posedge clk);
   endtask
endmodule

// ---- tb_top.sv ----
/*
 Self-checking bench for the data port, both variants side by side.
 Assumes adpp_host as bus master; the ten-bit copy only listens.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_top;
   logic        clk, rst, wm, cs_n, rd_n, wr_n, ok, stb;
   logic [11:0] res, hv, ww;
   logic [2:0]  chan, hi_o, hi_t;
   logic [7:0]  lo_o, lo_t;
   logic        lo_oe, b8_o, b8_oe, hi_oe, b8_t;
   int          fail_count, n_checks, strobes;
   wire  [7:0]  lo_w = lo_oe ? lo_o : hv[7:0];
   wire         b8_w = b8_oe ? b8_o : hv[8];
   wire  [2:0]  hi_w = hi_oe ? hi_o : hv[11:9];
   adpp_host HOST (.clk(clk), .dev_oe(lo_oe), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .v(hv));
   adpp_port DUT (.SYS_CLK(clk), .RST(rst), .CS_N(cs_n), .RD_N(rd_n),
      .WR_N(wr_n), .WORD_MODE(wm), .LOW_DATA_LINES_I(lo_w),
      .LOW_DATA_LINES_O(lo_o), .LOW_DATA_LINES_OE(lo_oe),
      .BIT8_OR_UPPER_BYTE_SELECT_I(b8_w), .BIT8_OR_UPPER_BYTE_SELECT_O(b8_o),
      .BIT8_OR_UPPER_BYTE_SELECT_OE(b8_oe), .HIGH_DATA_LINES_I(hi_w),
      .HIGH_DATA_LINES_O(hi_o), .HIGH_DATA_LINES_OE(hi_oe), .RESULT(res),
      .RESULT_CHAN(chan), .WR_WORD(ww), .WR_STROBE(stb));
   adpp_port #(.TEN_BIT(1'b1)) DUT_TEN (.SYS_CLK(clk), .RST(rst),
      .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .WORD_MODE(wm),
      .LOW_DATA_LINES_I(lo_w), .LOW_DATA_LINES_O(lo_t),
      .LOW_DATA_LINES_OE(), .BIT8_OR_UPPER_BYTE_SELECT_I(b8_w),
      .BIT8_OR_UPPER_BYTE_SELECT_O(b8_t), .BIT8_OR_UPPER_BYTE_SELECT_OE(),
      .HIGH_DATA_LINES_I(hi_w), .HIGH_DATA_LINES_O(hi_t),
      .HIGH_DATA_LINES_OE(), .RESULT(res), .RESULT_CHAN(chan),
      .WR_WORD(), .WR_STROBE());
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (stb === 1'b1) strobes <= strobes + 1;
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic need(input logic k);
      if (k !== 1'b1) begin
         fail_count++;
         end_of_test;
      end
   endtask
   task automatic rls;
      HOST.rel(ok);
      need(ok);
      `CHK({b8_oe, hi_oe}, 2'b00)
   endtask
   task automatic t_word_read;
      @(posedge clk);
      wm   <= 1'b1;
      res  <= 12'ha5f;
      chan <= 3'h5;
      HOST.go(1'b0, 12'h000, ok);
      need(ok);
      `CHK({hi_o, b8_o, lo_o}, 12'ha5f)
      `CHK({hi_oe, b8_oe}, 2'b11)
      `CHK({hi_t, b8_t, lo_t}, 12'h97c)
      rls;
   endtask
   task automatic t_byte_read;
      @(posedge clk);
      wm   <= 1'b0;
      res  <= 12'h3c6;
      chan <= 3'h6;
      HOST.go(1'b0, 12'h000, ok);
      need(ok);
      `CHK(lo_o, 8'hc6)
      `CHK({b8_oe, hi_oe}, 2'b00)
      `CHK(lo_t, 8'h18)
      rls;
      HOST.go(1'b0, 12'h100, ok);
      need(ok);
      `CHK(lo_o[3:0], 4'h3)
      `CHK(lo_o[7:4], 4'h6)
      `CHK(lo_t, 8'h6f)
      rls;
   endtask
   task automatic t_writes;
      int n;
      @(posedge clk);
      wm <= 1'b1;
      n = strobes;
      HOST.go(1'b1, 12'h6a3, ok);
      // Strobe is counted at the edge the host returns on; let it land
      @(posedge clk);
      #1;
      `CHK(strobes, n + 1)
      `CHK(ww, 12'h6a3)
      @(posedge clk);
      wm <= 1'b0;
      n = strobes;
      HOST.go(1'b1, 12'h05a, ok);
      @(posedge clk);
      #1;
      `CHK(strobes, n)
      HOST.go(1'b1, 12'h10b, ok);
      @(posedge clk);
      #1;
      `CHK(strobes, n + 1)
      `CHK(ww, 12'hb5a)
   endtask
   initial begin
      rst  = 1'b1;
      wm   = 1'b1;
      res  = 12'h000;
      chan = 3'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({lo_oe, b8_oe, hi_oe, stb}, 4'h0)
      `CHK(ww, 12'h000)
      t_word_read;
      t_byte_read;
      t_writes;
      end_of_test;
   end
endmodule
